// ---- common/scs_pkg.sv ----
// Purpose: Shared types and constants for the system control block.
// Assumes: One 250 MHz bus clock; 32-bit AXI4-Lite register port.
// Notes: Pin groups travel as packed structs; active-low pins end in _n.
package scs_pkg;

  typedef struct packed {
    logic [31:0] dl;
    logic [7:0] dp;
    logic [3:0] ap;
  } scs_lanes_t;

  typedef struct packed {
    logic hard_reset_in_n;
    logic soft_reset_in_n;
    logic external_irq_in_n;
    logic sys_mgmt_irq_in_n;
    logic machine_check_in_n;
    logic checkstop_in_n;
    logic quiesce_ack_n;
    logic tlb_sync_hold_in_n;
    logic xfer_error_ack_n;
  } scs_ctl_t;

  typedef enum {QS_RUN, QS_REQ, QS_QUIET} scs_qstate_t;

  localparam scs_ctl_t CTL_IDLE = '1;
  localparam scs_lanes_t LANES_ZERO = '0;

  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_VECTOR = 12'h008;
  localparam logic [11:0] OFF_RESV = 12'h00c;

  localparam int CTRL_EE = 0;
  localparam int CTRL_ME = 1;
  localparam int CTRL_IP = 2;
  localparam int CTRL_MCP_PIN_ENABLE_BIT = 3;
  localparam int CTRL_QEN = 4;
  localparam logic [4:0] CTRL_RST = 5'h04;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  localparam logic [31:0] VEC_OFFSET = 32'h0000_0100;
  localparam logic [31:0] PREFIX_ONES = 32'hfff0_0000;
  localparam logic [31:0] PREFIX_ZEROS = 32'h0000_0000;

  localparam logic [7:0] DP_LOW_LANES = 8'h0f;
  localparam logic [7:0] DP_ALL = 8'hff;
  localparam logic [3:0] AP_ALL = 4'hf;

  localparam logic FULL_RST = 1'b1;
  localparam logic BUS32_RST = 1'b0;
  localparam int RESV_LSB = 5;

endpackage

// ---- hdl/scs_sysctl.sv ----
// Purpose: System control pins of the processor: pinout and bus-width
//   straps, lane gating, interrupts, checkstop, resets, quiesce,
//   reservation and translation-sync hold.
// Assumes: All pins are asynchronous and pass two flip-flops; core-side
//   ports share aclk; ce low freezes every flip-flop.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module scs_sysctl
  import scs_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock, reset and freeze.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite register port.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Control pins, all active low.
  input wire scs_ctl_t ctl_pins,
  output logic checkstop_out_n,
  output logic quiesce_request_n,
  output logic reservation_out_n,
  // Gated lane pins: low data lanes, data parity, address parity.
  input wire scs_lanes_t lane_in,
  output scs_lanes_t lane_out,
  output scs_lanes_t lane_oe,
  // Open-drain parity-error pins.
  output logic addr_parity_error_out,
  output logic addr_parity_error_oe,
  output logic data_parity_error_out,
  output logic data_parity_error_oe,
  // Core side.
  input wire scs_lanes_t core_drive,
  input wire scs_lanes_t core_drive_oe,
  output scs_lanes_t core_sample,
  input wire logic core_ape_assert,
  input wire logic core_dpe_assert,
  input wire logic core_parity_err,
  input wire logic core_resv_set,
  input wire logic [31:0] core_resv_addr,
  input wire logic core_resv_clear,
  input wire logic core_snoop_valid,
  input wire logic [31:0] core_snoop_addr,
  input wire logic core_sync_pending,
  output logic completion_hold,
  output logic ext_irq_take,
  output logic smi_take,
  output logic mcheck_take,
  output logic clocks_off,
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  output logic snoop_stopped,
  output logic full_pinout,
  output logic bus_32bit
);

  scs_ctl_t ctl_s1_reg;
  scs_ctl_t ctl_s2_reg;
  scs_lanes_t lane_s1_reg;
  scs_lanes_t lane_s2_reg;
  scs_lanes_t mask;
  scs_qstate_t q_reg;
  scs_qstate_t q_next;
  logic hrst_prev_reg;
  logic srst_prev_reg;
  logic hrst_act;
  logic srst_act;
  logic hrst_fall;
  logic rst_fall;
  logic full_pinout_reg;
  logic bus32_reg;
  logic [4:0] ctrl_reg;
  logic halted_reg;
  logic halted_next;
  logic [3:0] cause_reg;
  logic [3:0] cause_now;
  logic resv_valid_reg;
  logic resv_valid_next;
  logic [31:RESV_LSB] resv_blk_reg;
  logic resv_kill;
  logic [31:0] vector_reg;
  logic aw_rdy_reg;
  logic w_rdy_reg;
  logic ar_rdy_reg;
  logic bvalid_reg;
  logic rvalid_reg;
  logic [1:0] bresp_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  logic [11:0] rd_off;
  logic [11:0] wr_off;

  // Disabled receivers read as zero at the core; the mask sits after the
  // synchroniser so that every pin still passes two flops before any gate.
  function automatic scs_lanes_t lane_mask(input logic full, input logic b32);
    scs_lanes_t m;
    m.dl = b32 ? 32'h0000_0000 : 32'hffff_ffff;
    m.dp = full ? (b32 ? DP_LOW_LANES : DP_ALL) : 8'h00;
    m.ap = full ? AP_ALL : 4'h0;
    return m;
  endfunction

  assign mask = lane_mask(full_pinout_reg, bus32_reg);
  assign hrst_act = ~ctl_s2_reg.hard_reset_in_n;
  assign srst_act = ~ctl_s2_reg.soft_reset_in_n;
  assign hrst_fall = hrst_prev_reg & ~hrst_act;
  assign rst_fall = hrst_fall | (srst_prev_reg & ~srst_act & ~hrst_act);

  // Two-flop synchronisers for every pin.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_s1_reg <= CTL_IDLE;
      ctl_s2_reg <= CTL_IDLE;
      lane_s1_reg <= LANES_ZERO;
      lane_s2_reg <= LANES_ZERO;
      hrst_prev_reg <= 1'b0;
      srst_prev_reg <= 1'b0;
    end else if (ce) begin
      ctl_s1_reg <= ctl_pins;
      ctl_s2_reg <= ctl_s1_reg;
      lane_s1_reg <= lane_in;
      lane_s2_reg <= lane_s1_reg;
      hrst_prev_reg <= hrst_act;
      srst_prev_reg <= srst_act;
    end
  end

  // Straps; the bus width is stored already forced by reduced pinout.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      full_pinout_reg <= FULL_RST;
      bus32_reg <= BUS32_RST;
    end else if (ce && hrst_fall) begin
      full_pinout_reg <= ~ctl_s2_reg.quiesce_ack_n;
      bus32_reg <= ~ctl_s2_reg.tlb_sync_hold_in_n | ctl_s2_reg.quiesce_ack_n;
    end
  end

  // Lane drivers: a disabled lane keeps its enable and drives zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lane_out <= LANES_ZERO;
      lane_oe <= LANES_ZERO;
      core_sample <= LANES_ZERO;
      addr_parity_error_out <= 1'b0;
      data_parity_error_out <= 1'b0;
      addr_parity_error_oe <= 1'b0;
      data_parity_error_oe <= 1'b0;
    end else if (ce) begin
      lane_out <= core_drive & mask;
      lane_oe <= core_drive_oe;
      core_sample <= lane_s2_reg & mask;
      addr_parity_error_out <= 1'b0;
      data_parity_error_out <= 1'b0;
      addr_parity_error_oe <= core_ape_assert & full_pinout_reg;
      data_parity_error_oe <= core_dpe_assert & full_pinout_reg;
    end
  end

  // Checkstop causes: pin, machine check, transfer error, parity error.
  always_comb begin
    cause_now[0] = ~ctl_s2_reg.checkstop_in_n;
    cause_now[1] = ~ctl_s2_reg.machine_check_in_n & ~ctrl_reg[CTRL_ME] & ctrl_reg[CTRL_MCP_PIN_ENABLE_BIT];
    cause_now[2] = ~ctl_s2_reg.xfer_error_ack_n & ~ctrl_reg[CTRL_ME];
    cause_now[3] = core_parity_err & full_pinout_reg & ~ctrl_reg[CTRL_ME];
    halted_next = hrst_act ? 1'b0 : (halted_reg | (|cause_now));
  end

  // Only a cold start leaves the checkstop state; a warm reset does not.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halted_reg <= 1'b0;
      cause_reg <= 4'h0;
      checkstop_out_n <= 1'b1;
      clocks_off <= 1'b0;
    end else if (ce) begin
      halted_reg <= halted_next;
      cause_reg <= hrst_act ? 4'h0 : (cause_reg | cause_now);
      checkstop_out_n <= ~halted_next;
      clocks_off <= halted_next;
    end
  end

  // Exception takes are levels; the core decides when to vector.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_irq_take <= 1'b0;
      smi_take <= 1'b0;
      mcheck_take <= 1'b0;
    end else if (ce) begin
      ext_irq_take <= ctrl_reg[CTRL_EE] & ~ctl_s2_reg.external_irq_in_n & ~halted_reg & ~hrst_act;
      smi_take <= ctrl_reg[CTRL_EE] & ~ctl_s2_reg.sys_mgmt_irq_in_n & ~halted_reg & ~hrst_act;
      mcheck_take <= ctrl_reg[CTRL_ME] & ~halted_reg & ~hrst_act
        & ((ctrl_reg[CTRL_MCP_PIN_ENABLE_BIT] & ~ctl_s2_reg.machine_check_in_n)
        | ~ctl_s2_reg.xfer_error_ack_n | (core_parity_err & full_pinout_reg));
    end
  end

  // Reset vector fetch on release of either reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_req <= 1'b0;
      fetch_addr <= PREFIX_ONES | VEC_OFFSET;
      vector_reg <= PREFIX_ONES | VEC_OFFSET;
    end else if (ce) begin
      fetch_req <= rst_fall;
      if (rst_fall) begin
        fetch_addr <= (ctrl_reg[CTRL_IP] ? PREFIX_ONES : PREFIX_ZEROS) | VEC_OFFSET;
        vector_reg <= (ctrl_reg[CTRL_IP] ? PREFIX_ONES : PREFIX_ZEROS) | VEC_OFFSET;
      end
    end
  end

  // Quiesce handshake.
  always_comb begin
    q_next = q_reg;
    case (q_reg)
      QS_RUN: begin
        if (ctrl_reg[CTRL_QEN]) q_next = QS_REQ;
      end
      QS_REQ: begin
        if (!ctrl_reg[CTRL_QEN]) q_next = QS_RUN;
        else if (!ctl_s2_reg.quiesce_ack_n) q_next = QS_QUIET;
      end
      QS_QUIET: begin
        if (!ctrl_reg[CTRL_QEN]) q_next = QS_RUN;
      end
      default: q_next = QS_RUN;
    endcase
    if (hrst_act) q_next = QS_RUN;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_reg <= QS_RUN;
      quiesce_request_n <= 1'b1;
      snoop_stopped <= 1'b0;
    end else if (ce) begin
      q_reg <= q_next;
      quiesce_request_n <= (q_next == QS_RUN);
      snoop_stopped <= (q_next == QS_QUIET);
    end
  end

  // Reservation; a new set wins over a clear or snoop kill in one cycle.
  assign resv_kill = core_resv_clear | hrst_act
    | (core_snoop_valid & (core_snoop_addr[31:RESV_LSB] == resv_blk_reg));
  assign resv_valid_next = core_resv_set | (resv_valid_reg & ~resv_kill);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resv_valid_reg <= 1'b0;
      resv_blk_reg <= '0;
      reservation_out_n <= 1'b1;
      completion_hold <= 1'b0;
      full_pinout <= FULL_RST;
      bus_32bit <= BUS32_RST;
    end else if (ce) begin
      resv_valid_reg <= resv_valid_next;
      if (core_resv_set) resv_blk_reg <= core_resv_addr[31:RESV_LSB];
      reservation_out_n <= full_pinout_reg ? ~resv_valid_next : 1'b0;
      completion_hold <= ~ctl_s2_reg.tlb_sync_hold_in_n & core_sync_pending;
      full_pinout <= full_pinout_reg;
      bus_32bit <= bus32_reg;
    end
  end

  // AXI4-Lite slave; address and data may arrive in either order.
  assign wr_fire = ~aw_rdy_reg & ~w_rdy_reg & ~bvalid_reg;
  assign wr_off = {awaddr_reg[11:2], 2'b00};
  assign rd_off = {s_axi_araddr[11:2], 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_reg <= 1'b1;
      w_rdy_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && aw_rdy_reg) begin
        aw_rdy_reg <= 1'b0;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && w_rdy_reg) begin
        w_rdy_reg <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (awaddr_reg[ADDR_W-1:4] == '0) ? RESP_OKAY : RESP_DECERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        aw_rdy_reg <= 1'b1;
        w_rdy_reg <= 1'b1;
      end
    end
  end

  // Hard reset overrides software so the cold start always sees the prefix set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
    end else if (ce) begin
      if (hrst_act) begin
        ctrl_reg <= CTRL_RST;
      end else if (wr_fire && wstrb_reg[0] && awaddr_reg[ADDR_W-1:4] == '0 && wr_off == OFF_CTRL) begin
        ctrl_reg <= wdata_reg[4:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_rdy_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && ar_rdy_reg) begin
        ar_rdy_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rresp_reg <= RESP_OKAY;
        rdata_reg <= 32'h0000_0000;
        if (s_axi_araddr[ADDR_W-1:4] != '0) begin
          rresp_reg <= RESP_DECERR;
        end else begin
          case (rd_off)
            OFF_CTRL: rdata_reg <= {27'h0, ctrl_reg};
            OFF_STATUS: rdata_reg <= {20'h0, cause_reg, 2'h0, completion_hold, resv_valid_reg,
              snoop_stopped, halted_reg, bus32_reg, full_pinout_reg};
            OFF_VECTOR: rdata_reg <= vector_reg;
            OFF_RESV: rdata_reg <= {resv_blk_reg, 5'h00};
            default: rresp_reg <= RESP_DECERR;
          endcase
        end
      end
      if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
        ar_rdy_reg <= 1'b1;
      end
    end
  end

  assign s_axi_awready = aw_rdy_reg;
  assign s_axi_wready = w_rdy_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ar_rdy_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Checks; a low ce freezes state, so checks pause with it.
  chk_reduced_lanes_low: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    !full_pinout_reg && $stable(full_pinout_reg) |-> lane_out.dp == 8'h00 && lane_out.ap == 4'h0
      && lane_out.dl == 32'h0000_0000)
    else $error("Disabled lane driven high in reduced pinout.");

  chk_bus32_forced: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    !full_pinout_reg |-> bus32_reg)
    else $error("Reduced pinout without 32-bit bus.");

  chk_drive_enable_kept: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    $past(core_drive_oe.ap) != 4'h0 |-> lane_oe.ap == $past(core_drive_oe.ap))
    else $error("Disabled pin not driven while it should be.");

  chk_parity_err_hiz: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    !full_pinout_reg && $stable(full_pinout_reg) |-> !addr_parity_error_oe && !data_parity_error_oe)
    else $error("Parity-error pin driven in reduced pinout.");

  chk_receivers_off: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    !full_pinout_reg && $past(!full_pinout_reg, 3) |-> core_sample.dp == 8'h00 && core_sample.ap == 4'h0)
    else $error("Disabled lane sampled in reduced pinout.");

  chk_pinout_strap: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    hrst_fall |=> full_pinout_reg == !$past(ctl_s2_reg.quiesce_ack_n))
    else $error("Pinout strap not captured.");

  chk_width_strap: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    hrst_fall && !ctl_s2_reg.quiesce_ack_n |=> bus32_reg == !$past(ctl_s2_reg.tlb_sync_hold_in_n))
    else $error("Bus width strap not captured.");

  chk_strap_hold: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    !hrst_fall |=> $stable(full_pinout_reg) && $stable(bus32_reg))
    else $error("Strap changed outside hard-reset release.");

  chk_ext_irq_take: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    ctrl_reg[CTRL_EE] && !ctl_s2_reg.external_irq_in_n && !halted_reg && !hrst_act |=> ext_irq_take)
    else $error("Enabled external interrupt not taken.");

  chk_ckstp_halt: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    !ctl_s2_reg.checkstop_in_n && !hrst_act |=> halted_reg && clocks_off)
    else $error("Checkstop pin did not halt.");

  chk_checkstop_out: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    checkstop_out_n == !halted_reg)
    else $error("Checkstop output disagrees with checkstop state.");

  chk_tea_ckstp: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    !ctl_s2_reg.xfer_error_ack_n && !ctrl_reg[CTRL_ME] && !hrst_act |=> halted_reg)
    else $error("Transfer error with checks off did not checkstop.");

  chk_fetch_vector: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    hrst_fall |=> fetch_req && fetch_addr == (PREFIX_ONES | VEC_OFFSET))
    else $error("Wrong fetch after hard reset.");

  chk_quiesce_req: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    ctrl_reg[CTRL_QEN] && !hrst_act |=> !quiesce_request_n)
    else $error("Quiesce request not raised.");

  chk_snoop_stop: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    q_reg == QS_REQ && ctrl_reg[CTRL_QEN] && !ctl_s2_reg.quiesce_ack_n && !hrst_act
      |=> snoop_stopped && !quiesce_request_n)
    else $error("Acknowledged quiesce not entered.");

  chk_resv_block: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    core_resv_set |=> resv_valid_reg && resv_blk_reg == $past(core_resv_addr[31:RESV_LSB]))
    else $error("Reservation block not recorded.");

  chk_resv_pin: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    full_pinout_reg && $stable(full_pinout_reg) |-> reservation_out_n == !resv_valid_reg)
    else $error("Reservation pin does not follow reservation bit.");

  chk_sync_hold: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    !ctl_s2_reg.tlb_sync_hold_in_n && core_sync_pending |=> completion_hold)
    else $error("Completion not held for pending sync.");

endmodule

// ---- sim/scs_sys_model.sv ----
// Purpose: System side of the control pins: strap levels, quiesce reply, DMA hold.
// Assumes: Straps are held a few cycles past hard-reset release so two sync flops see them.
// Notes: The acknowledge lags the request to stand in for draining snooped traffic.
`timescale 1ns/100ps
module scs_sys_model (
  // Clock and strap control.
  input wire logic aclk,
  input wire logic hard_n,
  input wire logic strap_full,
  input wire logic strap_32,
  // Quiesce and DMA.
  input wire logic quiesce_request_n,
  input wire logic dma_busy,
  output logic quiesce_ack_n,
  output logic tlb_sync_hold_in_n
);
  logic [2:0] hold = 3'h0;
  logic [2:0] qd = 3'h0;
  logic strap;
  always_ff @(posedge aclk) begin
    if (!hard_n) hold <= 3'h4;
    else if (hold != 3'h0) hold <= hold - 3'h1;
    qd <= {qd[1:0], ~quiesce_request_n};
  end
  assign strap = !hard_n || hold != 3'h0;
  assign quiesce_ack_n = strap ? !strap_full : !qd[2];
  assign tlb_sync_hold_in_n = strap ? !strap_32 : !dma_busy;
endmodule

// ---- sim/cpu_system_control_signals_tb.sv ----
// Purpose: Self-checking bench for the system control pins and registers.
// Assumes: Fixed waits cover the stated two-flop pin latency plus one.
// Notes: Checkstop is sticky, so the pin case runs last.
`timescale 1ns/100ps
module cpu_system_control_signals_tb;
  import scs_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, fetch_addr, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  scs_ctl_t ctl_pins;
  logic hard_n = 1, soft_n = 1, irq_n = 1, mgmt_n = 1, mchk_n = 1, stop_n = 1, err_n = 1;
  logic ack_n, tlb_n, sfull = 1, s32 = 0, dma = 0;
  logic checkstop_out_n, quiesce_request_n, reservation_out_n;
  scs_lanes_t lane_in = 0, lane_out, lane_oe, core_drive = 0, core_drive_oe = 0, core_sample;
  logic addr_parity_error_out, addr_parity_error_oe, data_parity_error_out, data_parity_error_oe;
  logic core_ape_assert = 0, core_dpe_assert = 0, core_parity_err = 0;
  logic core_resv_set = 0, core_resv_clear = 0, core_snoop_valid = 0, core_sync_pending = 0;
  logic [31:0] core_resv_addr = 0, core_snoop_addr = 0;
  logic completion_hold, ext_irq_take, smi_take, mcheck_take, clocks_off, fetch_req;
  logic snoop_stopped, full_pinout, bus_32bit;
  int miscompares = 0, n_tests = 0;
  assign ctl_pins = {hard_n, soft_n, irq_n, mgmt_n, mchk_n, stop_n, ack_n, tlb_n, err_n};
  always #2 aclk = ~aclk;
  scs_sysctl uut (.*);
  scs_sys_model sys (.aclk(aclk), .hard_n(hard_n), .strap_full(sfull), .strap_32(s32),
    .quiesce_request_n(quiesce_request_n), .dma_busy(dma), .quiesce_ack_n(ack_n),
    .tlb_sync_hold_in_n(tlb_n));
  task automatic close_out;
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [43:0] e, input logic [43:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", s, e, g);
      miscompares++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic hrst(input logic f, input logic b);
    sfull <= f;
    s32 <= b;
    hard_n <= 1'b0;
    cyc(4);
    hard_n <= 1'b1;
    cyc(8);
  endtask
  initial begin
    #20000;
    miscompares++;
    close_out;
  end
  initial begin
    cyc(6);
    aresetn <= 1'b1;
    cyc(1);
    hrst(1'b1, 1'b1);
    core_drive <= '1;
    core_drive_oe <= '1;
    lane_in <= '1;
    core_ape_assert <= 1'b1;
    cyc(6);
    chk("bus_32bit", 1, bus_32bit);
    chk("lane_out", {32'h0000_0000, 8'h0f, 4'hf}, lane_out);
    chk("core_sample", {32'h0000_0000, 8'h0f, 4'hf}, core_sample);
    chk("ape_oe", 1, addr_parity_error_oe);
    core_ape_assert <= 1'b0;
    hrst(1'b1, 1'b0);
    chk("full_pinout", 1, full_pinout);
    chk("bus_32bit", 0, bus_32bit);
    chk("fetch_addr", 32'hfff00100, fetch_addr);
    rd(OFF_CTRL, d, r);
    chk("ctrl", 32'h4, d);
    rd(12'h010, d, r);
    chk("unmapped", RESP_DECERR, r);
    wr(12'h010, 32'h0);
    chk("bresp", RESP_DECERR, r);
    wr(OFF_CTRL, 32'h0);
    chk("bresp", RESP_OKAY, r);
    soft_n <= 1'b0;
    cyc(4);
    soft_n <= 1'b1;
    cyc(8);
    chk("fetch_addr", 32'h100, fetch_addr);
    chk("full_pinout", 1, full_pinout);
    core_drive <= '1;
    core_drive_oe <= '1;
    lane_in <= '1;
    cyc(6);
    chk("lane_out", '1, lane_out);
    chk("core_sample", '1, core_sample);
    wr(OFF_CTRL, 32'h1);
    irq_n <= 1'b0;
    mgmt_n <= 1'b0;
    cyc(6);
    chk("ext_irq_take", 1, ext_irq_take);
    chk("smi_take", 1, smi_take);
    {irq_n, mgmt_n} <= 2'h3;
    wr(OFF_CTRL, 32'ha);
    mchk_n <= 1'b0;
    cyc(6);
    chk("mcheck_take", 1, mcheck_take);
    mchk_n <= 1'b1;
    wr(OFF_CTRL, 32'h10);
    cyc(10);
    chk("quiesce_request_n", 0, quiesce_request_n);
    chk("snoop_stopped", 1, snoop_stopped);
    wr(OFF_CTRL, 32'h0);
    core_resv_addr <= 32'h1234_567f;
    core_resv_set <= 1'b1;
    cyc(1);
    core_resv_set <= 1'b0;
    cyc(3);
    chk("reservation_out_n", 0, reservation_out_n);
    rd(OFF_RESV, d, r);
    chk("resv_addr", 32'h1234_5660, d);
    dma <= 1'b1;
    core_sync_pending <= 1'b1;
    cyc(6);
    chk("completion_hold", 1, completion_hold);
    dma <= 1'b0;
    err_n <= 1'b0;
    cyc(6);
    chk("checkstop_out_n", 0, checkstop_out_n);
    err_n <= 1'b1;
    hrst(1'b0, 1'b0);
    chk("checkstop_out_n", 1, checkstop_out_n);
    chk("full_pinout", 0, full_pinout);
    chk("bus_32bit", 1, bus_32bit);
    core_ape_assert <= 1'b1;
    core_dpe_assert <= 1'b1;
    cyc(6);
    chk("lane_out", 0, lane_out);
    chk("lane_oe", '1, lane_oe);
    chk("core_sample", 0, core_sample);
    chk("ape_oe", 0, addr_parity_error_oe);
    chk("dpe_oe", 0, data_parity_error_oe);
    stop_n <= 1'b0;
    cyc(6);
    chk("clocks_off", 1, clocks_off);
    chk("checkstop_out_n", 0, checkstop_out_n);
    close_out;
  end
endmodule
